// *** shared/madc_pkg.sv ***
/*
  constants and state layout for the monitor converter readout block.
  assumes a single 250 MHz system clock and a serial host on the pins.
*/
package madc_pkg;

    // register offsets on the serial port (15-bit address)
    localparam logic [14:0] MADC_ADDR_DET_EN = 15'h049;
    localparam logic [14:0] MADC_ADDR_CTRL   = 15'h04A;
    localparam logic [14:0] MADC_ADDR_RESULT = 15'h04B;

    // reset values
    localparam logic [7:0] MADC_DET_EN_RST = 8'h00;
    localparam logic [7:0] MADC_CTRL_RST   = 8'h00;
    localparam logic [7:0] MADC_RESULT_RST = 8'h00;

    // converter control field positions
    localparam int MADC_BIT_DONE    = 0;
    localparam int MADC_SEL_LO      = 1;
    localparam int MADC_SEL_HI      = 3;
    localparam int MADC_BIT_TRIGGER = 4;
    localparam int MADC_BIT_CLK_EN  = 5;
    localparam int MADC_BIT_CONV_EN = 6;
    localparam int MADC_BIT_RATE    = 7;

    // input selector codes
    localparam logic [2:0] MADC_SEL_TEMP = 3'h4;

    // serial frame: read flag, 15 address bits, 8 data bits
    localparam logic [4:0] MADC_INSTR_BITS = 5'h10;
    localparam logic [4:0] MADC_FRAME_BITS = 5'h18;

    // conversion clock rates and derived divider counts
    localparam int MADC_MCLK_HZ = 250_000_000;
    localparam int MADC_FAST_HZ = 2_000_000;
    localparam int MADC_SLOW_HZ = 250_000;
    localparam logic [9:0] MADC_DIV_FAST =
        10'(MADC_MCLK_HZ / MADC_FAST_HZ);
    localparam logic [9:0] MADC_DIV_SLOW =
        10'(MADC_MCLK_HZ / MADC_SLOW_HZ);

    // conversion clock periods per conversion
    localparam logic [3:0] MADC_CONV_TICKS = 4'h8;

    typedef struct packed {
        logic        sclk_prev;
        logic        cs_prev;
        logic [4:0]  bit_cnt;
        logic [14:0] shift;
        logic        is_read;
        logic [14:0] addr;
        logic [7:0]  tx;
        logic        sdio_out;
        logic        sdio_oe;
        logic        sdo;
        logic [7:0]  det_en;
        logic [7:0]  ctrl;
        logic [7:0]  result;
        logic [9:0]  div_cnt;
        logic        conv_tick;
        logic        busy;
        logic [3:0]  conv_cnt;
    } madc_state_t;

endpackage

// *** hw/madc_sync.sv ***
/*
  two-flop synchroniser, one per bit of the input vector.
  assumes inputs are asynchronous to mclk; only the second stage is used.
*/
`timescale 1ns/1ns
module madc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // async in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// *** hw/madc_readout.sv ***
/*
  monitor converter readout: serial register port, input selector,
  conversion clock divider and conversion sequencer.
  assumes the serial pins come from another domain and that the
  detector and temperature levels are steady codes on the mclk domain.
*/
`timescale 1ns/1ns
module madc_readout
    import madc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // serial port pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe,
    output logic            sdo,
    input  wire logic       four_wire,
    // sensed levels in front of the selector
    input  wire logic [7:0] detector_level_0,
    input  wire logic [7:0] detector_level_1,
    input  wire logic [7:0] detector_level_2,
    input  wire logic [7:0] detector_level_3,
    input  wire logic [7:0] temp_level,
    // controls toward the analog section
    output logic [3:0]      detector_enable,
    output logic [2:0]      input_select,
    output logic            converter_power,
    output logic            conv_clk_tick
);

    madc_state_t s;
    madc_state_t next_s;

    logic [2:0] pins_sync;
    logic       sclk_s;
    logic       cs_n_s;
    logic       sdi_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       mode_sel;

    // sclk, cs_n and sdio_in pass two flops before any logic sees them; chip select goes
    // in inverted so the flushed stage reads as deselected, no false edge
    madc_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .async_in ({sclk, ~cs_n, sdio_in}),
        .sync_out (pins_sync)
    );

    // edge detection on the synchronised pins
    assign sclk_s    = pins_sync[2];
    assign cs_n_s    = ~pins_sync[1];
    assign sdi_s     = pins_sync[0];
    assign sclk_rise = sclk_s & ~s.sclk_prev & ~cs_n_s;
    assign sclk_fall = ~sclk_s & s.sclk_prev & ~cs_n_s;
    assign cs_rise   = cs_n_s & ~s.cs_prev;
    // mode_sel is a synchronous strap from same-domain logic
    assign mode_sel  = four_wire;

    // register readback by address
    function automatic logic [7:0] madc_read(
        input logic [14:0] addr,
        input madc_state_t st
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            MADC_ADDR_DET_EN: val = st.det_en;
            MADC_ADDR_CTRL:   val = st.ctrl;
            MADC_ADDR_RESULT: val = st.result;
            default:          val = 8'h00;
        endcase
        return val;
    endfunction

    // five-way selector; unpowered detectors and bad codes read zero
    function automatic logic [7:0] madc_pick(
        input logic [2:0] sel,
        input logic [3:0] en,
        input logic [7:0] d0,
        input logic [7:0] d1,
        input logic [7:0] d2,
        input logic [7:0] d3,
        input logic [7:0] t
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (sel)
            3'h0:          val = en[0] ? d0 : 8'h00;
            3'h1:          val = en[1] ? d1 : 8'h00;
            3'h2:          val = en[2] ? d2 : 8'h00;
            3'h3:          val = en[3] ? d3 : 8'h00;
            MADC_SEL_TEMP: val = t;
            default:       val = 8'h00;
        endcase
        return val;
    endfunction

    // next-state logic for the whole block
    always_comb begin
        logic [14:0] addr_now;
        logic [7:0]  wdata;
        logic [9:0]  div_lim;
        addr_now = {s.shift[13:0], sdi_s};
        wdata    = {s.shift[6:0], sdi_s};
        div_lim  = 10'h000;
        next_s   = s;
        next_s.sclk_prev = sclk_s;
        next_s.cs_prev   = cs_n_s;
        next_s.conv_tick = 1'b0;

        // serial shift on rising edges, msb first
        if (sclk_rise && s.bit_cnt != MADC_FRAME_BITS) begin
            next_s.shift   = {s.shift[13:0], sdi_s};
            next_s.bit_cnt = s.bit_cnt + 5'h01;
            if (s.bit_cnt == MADC_INSTR_BITS - 5'h01) begin
                next_s.is_read = s.shift[14];
                next_s.addr    = addr_now;
                next_s.tx      = madc_read(addr_now, s);
            end
            if (s.bit_cnt == MADC_FRAME_BITS - 5'h01) begin
                next_s.tx = wdata;
            end
        end

        // read data leaves on falling edges after the instruction
        if (sclk_fall && s.is_read && s.bit_cnt >= MADC_INSTR_BITS
            && s.bit_cnt != MADC_FRAME_BITS) begin
            next_s.sdio_out = ~mode_sel & s.tx[7];
            next_s.sdo      = mode_sel & s.tx[7];
            next_s.sdio_oe  = ~mode_sel;
            next_s.tx       = {s.tx[6:0], 1'b0};
        end

        // chip select high ends the frame and releases the line
        if (cs_n_s) begin
            next_s.bit_cnt  = 5'h00;
            next_s.is_read  = 1'b0;
            next_s.sdio_oe  = 1'b0;
            next_s.sdio_out = 1'b0;
            next_s.sdo      = 1'b0;
        end

        // conversion clock divider, stopped while the clock is gated
        // rate select
        div_lim = s.ctrl[MADC_BIT_RATE] ? MADC_DIV_SLOW : MADC_DIV_FAST;
        if (s.ctrl[MADC_BIT_CLK_EN]) begin
            if (s.div_cnt >= div_lim - 10'h001) begin
                next_s.div_cnt   = 10'h000;
                next_s.conv_tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 10'h001;
            end
        end else begin
            next_s.div_cnt = 10'h000;
        end

        // conversion advances only on ticks while powered
        // power gate
        if (s.busy && s.conv_tick && s.ctrl[MADC_BIT_CONV_EN]) begin
            if (s.conv_cnt == MADC_CONV_TICKS - 4'h1) begin
                next_s.result = madc_pick(
                    s.ctrl[MADC_SEL_HI:MADC_SEL_LO], s.det_en[3:0],
                    detector_level_0, detector_level_1,
                    detector_level_2, detector_level_3, temp_level);
                next_s.ctrl[MADC_BIT_DONE]    = 1'b1;
                next_s.ctrl[MADC_BIT_TRIGGER] = 1'b0;
                next_s.busy                   = 1'b0;
                next_s.conv_cnt               = 4'h0;
            end else begin
                next_s.conv_cnt = s.conv_cnt + 4'h1;
            end
        end

        if (cs_rise && !s.is_read && s.bit_cnt == MADC_FRAME_BITS) begin
            if (s.addr == MADC_ADDR_DET_EN) begin
                next_s.det_en = s.tx;
            end
            if (s.addr == MADC_ADDR_CTRL) begin
                // selector field stored; done bit stays read-only
                next_s.ctrl[7:1] = s.tx[7:1];
                if (s.tx[MADC_BIT_TRIGGER]) begin
                    next_s.busy     = 1'b1;
                    next_s.conv_cnt = 4'h0;
                    next_s.ctrl[MADC_BIT_DONE] = 1'b0;
                end
            end
        end
    end

    // single state register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s <= '{
                sclk_prev: 1'b0, cs_prev: 1'b1, bit_cnt: 5'h00,
                shift: 15'h0000, is_read: 1'b0, addr: 15'h0000,
                tx: 8'h00, sdio_out: 1'b0, sdio_oe: 1'b0, sdo: 1'b0,
                det_en: MADC_DET_EN_RST, ctrl: MADC_CTRL_RST,
                result: MADC_RESULT_RST, div_cnt: 10'h000,
                conv_tick: 1'b0, busy: 1'b0, conv_cnt: 4'h0};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign sdio_out        = s.sdio_out;
    assign sdio_oe         = s.sdio_oe;
    assign sdo             = s.sdo;
    assign detector_enable = s.det_en[3:0];
    assign input_select    = s.ctrl[MADC_SEL_HI:MADC_SEL_LO];
    assign converter_power = s.ctrl[MADC_BIT_CONV_EN];
    assign conv_clk_tick   = s.conv_tick;

endmodule

// *** dv/madc_chk_assertions.sv ***
/* checker on the readout pins: ticks, read drive, commit timing.
   assumes one mclk domain; bound to the readout at the foot. */
`timescale 1ns/1ns
module madc_chk (
    // clock, reset and serial pins
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       cs_n,
    input wire logic       four_wire,
    input wire logic       sdio_oe,
    input wire logic       sdo,
    // controls toward the analog section
    input wire logic [2:0] input_select,
    input wire logic       converter_power,
    input wire logic       conv_clk_tick
);
    logic [10:0] gap;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // cycles since the last tick, saturating so it never wraps
    always_ff @(posedge mclk) begin
        if (!nrst || conv_clk_tick)
            gap <= 11'h000;
        else if (gap != 11'h7FF)
            gap <= gap + 11'h001;
    end
    // tick shape and spacing, read drive, commit only at deselect
    property p_pulse; conv_clk_tick |=> !conv_clk_tick [*8]; endproperty
    property p_gap; conv_clk_tick |-> gap >= 11'h07C; endproperty
    property p_oe3; sdio_oe |-> !four_wire; endproperty
    property p_sdo3; !four_wire |-> !sdo; endproperty
    property p_oe_idle; cs_n [*6] |-> !sdio_oe; endproperty
    property p_sdo_idle; cs_n [*6] |-> !sdo; endproperty
    property p_sel; !cs_n [*8] |=> $stable(input_select); endproperty
    property p_pwr; !cs_n [*8] |=> $stable(converter_power); endproperty
    a_pulse: assert property (p_pulse) else $error("long tick");
    a_gap: assert property (p_gap) else $error("tick too soon");
    a_oe3: assert property (p_oe3) else $error("oe in 4-wire");
    a_sdo3: assert property (p_sdo3) else $error("sdo in 3-wire");
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo idle");
    a_sel: assert property (p_sel) else $error("select early");
    a_pwr: assert property (p_pwr) else $error("power early");
    // main scenarios reached
    cover property (conv_clk_tick);
    cover property (sdio_oe);
    cover property ($rose(converter_power));
endmodule
bind madc_readout madc_chk u_madc_chk (.mclk(mclk), .nrst(nrst),
    .cs_n(cs_n), .four_wire(four_wire), .sdio_oe(sdio_oe), .sdo(sdo),
    .input_select(input_select), .converter_power(converter_power),
    .conv_clk_tick(conv_clk_tick));

// *** dv/madc_host.sv ***
/* serial host model: one 24-bit frame per call, clock parked low.
   assumes the bench resolves sdio from the oe pin and feeds miso. */
`timescale 1ns/1ns
module madc_host (
    // serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    // deselected and quiet at start
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // read flag, address, data, msb first; sampled at each rising edge
    task automatic xfer(input logic rd, input logic [14:0] a,
                        input logic [7:0] w, output logic [7:0] r);
        logic [23:0] f;
        f = {rd, a, w};
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            // released line toggles so a stale bit cannot pass
            mosi = (rd && i < 8) ? ~mosi : f[i];
            #63;
            if (i < 8)
                r[i] = miso;
            sclk = 1'b1;
            #62;
        end
        sclk = 1'b0;
        mosi = ~mosi;
        #63;
        cs_n = 1'b1;
        #100;
    endtask
endmodule

// *** dv/tb.sv ***
/* bench for the readout driven through the serial host model.
   assumes the checker binds itself to the readout. */
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected at %0t in %m", $time); end end
module tb
    import madc_pkg::*;
;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       four_wire = 1'b0;
    logic [7:0] lvl [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    logic [7:0] dets = 8'h0A;
    logic [7:0] rd;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    wire        sclk, cs_n, mosi, sdio_out, sdio_oe, sdo, pwr, tick;
    wire  [3:0] det_en;
    wire  [2:0] sel;
    // shared sdio line: shows the host's own bit unless the device drives
    wire        sdio_in = sdio_oe ? sdio_out : mosi;
    wire        miso = four_wire ? sdo : sdio_in;
    // 4 ns clock
    always #2 mclk = ~mclk;
    // device and host
    madc_readout u_madc_readout (.mclk(mclk), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .sdo(sdo), .four_wire(four_wire),
        .detector_level_0(lvl[0]), .detector_level_1(lvl[1]),
        .detector_level_2(lvl[2]), .detector_level_3(lvl[3]),
        .temp_level(lvl[4]), .detector_enable(det_en),
        .input_select(sel), .converter_power(pwr), .conv_clk_tick(tick));
    madc_host u_madc_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));
    // verdict and stop
    task automatic end_sim();
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hung run short, well above the expected length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            end_sim();
        end
    end
    // one frame; read data lands in rd
    task automatic xf(input logic rw, input logic [14:0] a,
                      input logic [7:0] w);
        u_madc_host.xfer(rw, a, w, rd);
    endtask
    // read and compare
    task automatic rdc(input logic [14:0] a, input logic [7:0] e);
        xf(1'b1, a, 8'h00);
        `CHK(rd, e)
    endtask
    // reset values, read-only result, enables, both wirings
    task automatic t_regs();
        rdc(MADC_ADDR_CTRL, MADC_CTRL_RST);
        rdc(MADC_ADDR_DET_EN, MADC_DET_EN_RST);
        xf(1'b0, MADC_ADDR_RESULT, 8'h5A);
        rdc(MADC_ADDR_RESULT, MADC_RESULT_RST);
        rdc(15'h04C, 8'h00);
        xf(1'b0, MADC_ADDR_DET_EN, dets);
        `CHK(det_en, dets[3:0])
        @(negedge mclk);
        four_wire = 1'b1;
        rdc(MADC_ADDR_DET_EN, dets);
        @(negedge mclk);
        four_wire = 1'b0;
    endtask
    // one conversion: start, tick period, poll, result
    task automatic t_conv(input logic [2:0] s, input logic slow);
        logic [7:0] c;
        logic [7:0] e;
        int         n;
        c = {slow, 3'b111, s, 1'b0};
        e = (s == 3'h4) ? lvl[4] : (dets[s] ? lvl[s] : 8'h00);
        xf(1'b0, MADC_ADDR_CTRL, c);
        `CHK(sel, s)
        `CHK(pwr, 1'b1)
        // second pass counts one whole period
        repeat (2) begin
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (tick !== 1'b1 && n < 2000);
        end
        `CHK(n, slow ? 1000 : 125)
        rdc(MADC_ADDR_CTRL, c);
        for (n = 0; n < 20 && rd[0] !== 1'b1; n++)
            xf(1'b1, MADC_ADDR_CTRL, 8'h00);
        `CHK(rd, c ^ 8'h11)
        rdc(MADC_ADDR_RESULT, e);
    endtask
    // clock gate, then power gate, each stalls a started conversion
    task automatic t_gate();
        logic [7:0] v;
        int         n;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h38 : 8'h59;
            xf(1'b0, MADC_ADDR_CTRL, v);
            `CHK(pwr, v[6])
            n = 0;
            repeat (1250) begin
                @(negedge mclk);
                n += int'(tick);
            end
            `CHK(n, v[5] ? 10 : 0)
            rdc(MADC_ADDR_CTRL, v & 8'hFE);
        end
    endtask
    // main sequence; gate runs before the slow rate to keep phase simple
    initial begin
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        t_regs();
        for (int s = 0; s < 5; s++)
            t_conv(3'(s), 1'b0);
        t_gate();
        t_conv(3'h3, 1'b1);
        end_sim();
    end
endmodule
